// File: rtl/iep_pkg.sv
// Package for the interrupt-enable, power-down arming and port-zero read decoder.
// Assumes a 10-bit instruction word presented by the program sequencer.
package iep_pkg;

  localparam int unsigned INSN_W = 10;
  localparam int unsigned DATA_W = 4;

  // Opcodes of the three decoded single-word instructions
  localparam logic [INSN_W-1:0] OPC_SET_IRQ_EN = 10'h005;
  localparam logic [INSN_W-1:0] OPC_ARM_PD     = 10'h05B;
  localparam logic [INSN_W-1:0] OPC_READ_P0    = 10'h260;

  // Delay from the enable instruction to interrupt acceptance, in machine cycles
  localparam int unsigned IRQ_EN_DELAY = 1;

  localparam logic [DATA_W-1:0] ACC_RST = 4'h0;

  // Instruction presented for execution
  typedef struct packed {
    logic              valid;
    logic [INSN_W-1:0] word;
  } iep_insn_t;

  // Results handed back to the core datapath
  typedef struct packed {
    logic              acc_we;
    logic [DATA_W-1:0] acc_data;
    logic              carry_we;
    logic              skip_next;
    logic              words_used;
  } iep_result_t;

endpackage

// File: rtl/iep_decoder.sv
// Decoder and executor for the interrupt-enable, power-down arming and port-zero input instructions.
// Assumes one instruction per ref_clk_i cycle (one machine cycle) from the sequencer, port pins asynchronous.
`timescale 1ns/1ps
`default_nettype none

// Function
// - The interrupt-enable instruction writes 1 into the interrupt enable flag in one single-word cycle.
// - Interrupt acceptance becomes effective only one machine cycle after the enable instruction executes.
// - The arming instruction makes the next power-down instruction of either type valid only if no instruction other than an arm comes first.
// - The port-zero input instruction loads the accumulator with the 4-bit port levels in one cycle.
module iep_decoder #(
  parameter int unsigned DATA_W = iep_pkg::DATA_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire iep_pkg::iep_insn_t insn_i,
  input  wire logic              irq_disable_i,
  input  wire logic              powerdown_op_i,
  input  wire logic              deep_powerdown_op_i,
  input  wire logic [DATA_W-1:0] port_zero_i,
  output var  logic              irq_enable_flag_o,
  output var  logic              irq_accept_en_o,
  output var  logic              pd_valid_o,
  output var  logic              deep_pd_valid_o,
  output var  logic [DATA_W-1:0] acc_o,
  output var  iep_pkg::iep_result_t result_o
);

  // ***************************************************************
  // Decode helpers
  // ***************************************************************
  function automatic logic is_op(input iep_pkg::iep_insn_t i, input logic [iep_pkg::INSN_W-1:0] opc);
    is_op = i.valid && (i.word == opc);
  endfunction

  // ***************************************************************
  // Port synchroniser
  // ***************************************************************
  // Pins are asynchronous to ref_clk_i; only the second stage feeds logic
  logic [DATA_W-1:0] p0_meta_r;
  logic [DATA_W-1:0] p0_meta_nxt;
  logic [DATA_W-1:0] p0_sync_r;
  logic [DATA_W-1:0] p0_sync_nxt;

  always_comb begin
    p0_meta_nxt = port_zero_i;
    p0_sync_nxt = p0_meta_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p0_meta_r <= '0;
      p0_sync_r <= '0;
    end else begin
      p0_meta_r <= p0_meta_nxt;
      p0_sync_r <= p0_sync_nxt;
    end
  end

  // ***************************************************************
  // Instruction decode
  // ***************************************************************
  logic do_ei;
  logic do_arm;
  logic do_rd;
  logic is_pd_any;

  assign do_ei     = is_op(insn_i, iep_pkg::OPC_SET_IRQ_EN);
  assign do_arm    = is_op(insn_i, iep_pkg::OPC_ARM_PD);
  assign do_rd     = is_op(insn_i, iep_pkg::OPC_READ_P0);
  assign is_pd_any = powerdown_op_i | deep_powerdown_op_i;

  // ***************************************************************
  // Interrupt enable flag
  // ***************************************************************
  logic ie_r;
  logic ie_nxt;

  // Enable beats a disable presented in the same cycle
  always_comb begin
    ie_nxt = ie_r;
    if (do_ei) begin
      ie_nxt = 1'b1;
    end else if (irq_disable_i) begin
      ie_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ie_r <= 1'b0;
    end else begin
      ie_r <= ie_nxt;
    end
  end

  // ***************************************************************
  // Interrupt acceptance delay
  // ***************************************************************
  // Acceptance trails the registered flag, so an interrupt pending during the
  // enable cycle itself is not taken yet; the delay must stay at least one
  localparam int unsigned ACC_DLY = iep_pkg::IRQ_EN_DELAY;

  logic [ACC_DLY-1:0] acc_pipe_r;
  logic [ACC_DLY-1:0] acc_pipe_nxt;

  always_comb begin
    acc_pipe_nxt    = acc_pipe_r << 1;
    acc_pipe_nxt[0] = ie_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_pipe_r <= '0;
    end else begin
      acc_pipe_r <= acc_pipe_nxt;
    end
  end

  // ***************************************************************
  // Power-down arming
  // ***************************************************************
  // The arm lasts one instruction: any valid instruction other than a fresh
  // arm, or any power-down pulse without a fresh arm, consumes it; idle cycles keep it pending
  typedef enum logic [1:0] {
    ARM_IDLE  = 2'b01,
    ARM_READY = 2'b10
  } iep_arm_state_t;

  iep_arm_state_t arm_state_r;
  iep_arm_state_t arm_state_nxt;
  logic           pd_r;
  logic           pd_nxt;
  logic           dpd_r;
  logic           dpd_nxt;

  always_comb begin
    arm_state_nxt = arm_state_r;
    pd_nxt        = 1'b0;
    dpd_nxt       = 1'b0;
    case (arm_state_r)
      ARM_IDLE: begin
        if (do_arm) begin
          arm_state_nxt = ARM_READY;
        end
      end
      ARM_READY: begin
        // Plain power-down wins when both types arrive together
        pd_nxt  = powerdown_op_i;
        dpd_nxt = deep_powerdown_op_i && !powerdown_op_i;
        if (do_arm) begin
          arm_state_nxt = ARM_READY;
        end else if (insn_i.valid || is_pd_any) begin
          arm_state_nxt = ARM_IDLE;
        end
      end
      default: begin
        arm_state_nxt = ARM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arm_state_r <= ARM_IDLE;
      pd_r        <= 1'b0;
      dpd_r       <= 1'b0;
    end else begin
      arm_state_r <= arm_state_nxt;
      pd_r        <= pd_nxt;
      dpd_r       <= dpd_nxt;
    end
  end

  // ***************************************************************
  // Accumulator load
  // ***************************************************************
  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] acc_nxt;

  // The loaded value is the synchronised pins, two cycles behind the pads
  always_comb begin
    acc_nxt = acc_r;
    if (do_rd) begin
      acc_nxt = p0_sync_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_r <= DATA_W'(iep_pkg::ACC_RST);
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ***************************************************************
  // Result to the core datapath
  // ***************************************************************
  localparam int unsigned RES_W = iep_pkg::DATA_W;

  iep_pkg::iep_result_t res_r;
  iep_pkg::iep_result_t res_nxt;

  // None of the three touches carry or the skip logic; each is one word
  always_comb begin
    res_nxt            = '0;
    res_nxt.acc_we     = do_rd;
    res_nxt.acc_data   = RES_W'(p0_sync_r);
    res_nxt.carry_we   = 1'b0;
    res_nxt.skip_next  = 1'b0;
    res_nxt.words_used = do_ei | do_arm | do_rd;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_r <= '0;
    end else begin
      res_r <= res_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign irq_enable_flag_o = ie_r;
  assign irq_accept_en_o   = acc_pipe_r[ACC_DLY-1];
  assign pd_valid_o        = pd_r;
  assign deep_pd_valid_o   = dpd_r;
  assign acc_o             = acc_r;
  assign result_o          = res_r;

endmodule

`default_nettype wire

// File: tb/iep_chk.sv
// Checker for the enable, arming and port-read decoder.
// Sees only the decoder's ports and is bound to it from the testbench.
`timescale 1ns/1ps
`default_nettype none
module iep_chk #(parameter int unsigned DATA_W = iep_pkg::DATA_W) (
  input wire logic ref_clk_i, rst_n_i, irq_disable_i, powerdown_op_i, deep_powerdown_op_i,
  input wire iep_pkg::iep_insn_t insn_i, input wire logic [DATA_W-1:0] port_zero_i,
  input wire logic irq_enable_flag_o, irq_accept_en_o, pd_valid_o, deep_pd_valid_o,
  input wire logic [DATA_W-1:0] acc_o, input wire iep_pkg::iep_result_t result_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire en = insn_i.valid && insn_i.word == iep_pkg::OPC_SET_IRQ_EN;
  wire rd = insn_i.valid && insn_i.word == iep_pkg::OPC_READ_P0;
  AST_EN: assert property (en |=> irq_enable_flag_o) else $error("flag not set");
  AST_ACCEPT: assert property ($rose(irq_enable_flag_o) |-> !irq_accept_en_o ##1 irq_accept_en_o)
    else $error("accept timing");
  AST_REFUSE: assert property (insn_i.valid && insn_i.word != iep_pkg::OPC_ARM_PD ##1 powerdown_op_i
    |=> !pd_valid_o) else $error("unarmed pd");
  AST_DEEP: assert property (deep_pd_valid_o |-> $past(deep_powerdown_op_i) && !pd_valid_o)
    else $error("deep pd cause");
  // Pins pass a two-flop synchroniser before the load edge
  AST_ACC: assert property (rd |=> result_o.acc_we && acc_o == $past(port_zero_i, 3))
    else $error("acc load");
  AST_NOSIDE: assert property (!result_o.carry_we && !result_o.skip_next) else $error("carry or skip");
  AST_WORD: assert property (en || rd |=> result_o.words_used) else $error("word count");
  cover property (en ##2 irq_accept_en_o);
  cover property (rd ##1 result_o.acc_we);
  cover property (pd_valid_o);
  cover property (deep_pd_valid_o);
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench: random instruction streams against a behavioural model.
// Drives every decoder input except ref_clk_i by non-blocking assignment at the rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin checks_done++; if ((a)!==(b)) begin errors++; $display("CHECK FAILED %0t %h %h",$time,a,b); end end
module testbench;
  logic ref_clk_i = 0, rst_n_i = 0, irq_disable_i = 0, powerdown_op_i = 0, deep_powerdown_op_i = 0;
  logic [3:0] port_zero_i = 4'h0, acc_o;
  logic irq_enable_flag_o, irq_accept_en_o, pd_valid_o, deep_pd_valid_o;
  iep_pkg::iep_insn_t insn_i = '0;
  iep_pkg::iep_result_t result_o;
  int errors = 0, checks_done = 0, seed = 32'h010FB059, r, m_f, m_a, m_arm, m_p, m_d, m_acc, m_we, m_w, q[$];
  iep_decoder i_iep_decoder (.ref_clk_i, .rst_n_i, .insn_i, .irq_disable_i, .powerdown_op_i,
    .deep_powerdown_op_i, .port_zero_i, .irq_enable_flag_o, .irq_accept_en_o, .pd_valid_o,
    .deep_pd_valid_o, .acc_o, .result_o);
  initial forever #50 ref_clk_i = ~ref_clk_i;
  task results; begin
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  end endtask
  initial begin #400000; errors++; results(); end
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin m_f = 0; m_a = 0; m_arm = 0; m_p = 0; m_d = 0; m_acc = 0; m_we = 0; m_w = 0; q = {0, 0}; end
    else begin
      m_a = m_f;
      m_p = m_arm && powerdown_op_i;
      m_d = m_arm && deep_powerdown_op_i && !powerdown_op_i;
      m_we = insn_i.valid && insn_i.word == iep_pkg::OPC_READ_P0;
      m_w = insn_i.valid && (insn_i.word inside {iep_pkg::OPC_SET_IRQ_EN, iep_pkg::OPC_ARM_PD, iep_pkg::OPC_READ_P0});
      if (m_we) m_acc = q[0];
      q.push_back(port_zero_i);
      void'(q.pop_front());
      // Enable beats a disable in the same cycle
      if (insn_i.valid && insn_i.word == iep_pkg::OPC_SET_IRQ_EN) m_f = 1; else if (irq_disable_i) m_f = 0;
      if (insn_i.valid && insn_i.word == iep_pkg::OPC_ARM_PD) m_arm = 1;
      else if (insn_i.valid || powerdown_op_i || deep_powerdown_op_i) m_arm = 0;
    end
  end
  always @(negedge ref_clk_i) if (rst_n_i) begin
    `CHK(irq_enable_flag_o, m_f[0])
    `CHK(irq_accept_en_o, m_a[0])
    `CHK({pd_valid_o, deep_pd_valid_o}, {m_p[0], m_d[0]})
    `CHK({result_o.acc_we, acc_o}, {m_we[0], m_acc[3:0]})
    if (result_o.acc_we) `CHK(result_o.acc_data, m_acc[3:0])
    `CHK({result_o.carry_we, result_o.skip_next, result_o.words_used}, {2'h0, m_w[0]})
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2000) begin
      @(posedge ref_clk_i);
      r = $random(seed);
      insn_i.valid <= r[2] | r[3];
      powerdown_op_i <= r[6:4] == 0;
      deep_powerdown_op_i <= r[9:7] == 0;
      irq_disable_i <= r[12:10] == 0;
      port_zero_i <= r[19:16];
      // Case 1 never arms in a cycle with a power-down pulse; only a random default word can still hit that overlap
      case (r[1:0])
        0: insn_i.word <= iep_pkg::OPC_SET_IRQ_EN;
        1: insn_i.word <= (r[6:4] == 0 || r[9:7] == 0) ? iep_pkg::OPC_READ_P0 : iep_pkg::OPC_ARM_PD;
        2: insn_i.word <= iep_pkg::OPC_READ_P0;
        default: insn_i.word <= r[29:20];
      endcase
    end
    repeat (3) @(posedge ref_clk_i);
    results();
  end
endmodule
bind iep_decoder iep_chk #(.DATA_W(DATA_W)) i_iep_chk (.ref_clk_i, .rst_n_i, .irq_disable_i, .powerdown_op_i,
  .deep_powerdown_op_i, .insn_i, .port_zero_i, .irq_enable_flag_o, .irq_accept_en_o, .pd_valid_o,
  .deep_pd_valid_o, .acc_o, .result_o);
`default_nettype wire
